//--- verilog/program_space_table_access.sv
// Table read and write data path between the core and program memory
//
// Overview of operation
// - Low-word ops reach program low word directly
// - High-word ops alone reach upper program byte
// - Program counter steps two per program word
// - Two 16-bit spaces share one address range
// - Every table op has word or byte mode
// - Low word read: P15..0 to D15..0
// - Low byte read: byte select picks byte
// - High word read: P23..16, D15..8 zero
// - High byte read: phantom byte reads zero
// - Page register supplies page for all ops
// - Page bit 7 selects configuration space
// - Configuration space is read-only, ID locations
`timescale 1ns/1ns
`include "table_access_regs.svh"
module program_space_table_access #(
   parameter int          WORD_ADDR_W    = 10,
   // Identification values are arbitrary
   parameter logic [23:0] DEVICE_ID_WORD = 24'h00A5C3,
   parameter logic [23:0] DEVICE_REV_WORD = 24'h000102
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        op_valid,
   input  wire table_access_pkg::table_op_t op_kind,
   input  wire logic                        byte_mode,
   input  wire logic [15:0]                 table_address,
   input  wire logic [7:0]                  table_page_select,
   input  wire logic [15:0]                 write_data,
   input  wire logic                        pc_step,
   input  wire logic                        pc_load,
   input  wire logic [23:0]                 pc_load_value,
   output logic                             rd_valid_q,
   output logic      [15:0]                 rd_data_q,
   output logic                             wr_done_q,
   output logic                             cfg_write_ignored_q,
   output logic      [23:0]                 program_counter_q
);
   import table_access_pkg::*;

   localparam int IDX_W = 22;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   function automatic logic is_read_op(input table_op_t k);
      return (k == table_read_low_word) || (k == table_read_high_word);
   endfunction

   function automatic logic [2:0] write_lanes(input table_op_t k, input logic bm,
                                              input logic sel);
      logic [2:0] l;
      l = 3'h0;
      case (k)
         table_write_low_word: l = bm ? (sel ? 3'h2 : 3'h1) : 3'h3;
         table_write_high_word: l = (bm && sel) ? 3'h0 : 3'h4;
         default: l = 3'h0;
      endcase
      return l;
   endfunction

   function automatic logic [23:0] cfg_word(input logic [7:0] page, input logic [15:0] a);
      logic [23:0] w;
      w = 24'h000000;
      if (page == `PST_CFG_ID_PAGE && {a[15:1], 1'b0} == `PST_CFG_ID_ADDR) begin
         w = DEVICE_ID_WORD;
      end else if (page == `PST_CFG_ID_PAGE && {a[15:1], 1'b0} == `PST_CFG_REV_ADDR) begin
         w = DEVICE_REV_WORD;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Request decode and store access
   logic [IDX_W-1:0]       word_index;
   logic                   in_range;
   logic                   cfg_space;
   logic [2:0]             mem_we;
   logic [23:0]            mem_wdata;
   logic [23:0]            mem_rdata;

   logic                   s1_valid_q, s1_valid_d;
   table_op_t              s1_kind_q, s1_kind_d;
   logic                   s1_byte_q, s1_byte_d;
   logic                   s1_sel_q, s1_sel_d;
   logic                   s1_cfg_q, s1_cfg_d;
   logic                   s1_hit_q, s1_hit_d;
   logic [7:0]             s1_page_q, s1_page_d;
   logic [15:0]            s1_addr_q, s1_addr_d;

   always_comb begin
      // Address pair maps program word; PC and data addresses step alike
      word_index = {table_page_select[6:0], table_address[15:1]};
      in_range   = (word_index >> WORD_ADDR_W) == '0;
      cfg_space  = table_page_select[`PST_CFG_SPACE_BIT];
      mem_we     = 3'h0;
      if (op_valid && !is_read_op(op_kind) && !cfg_space && in_range) begin
         mem_we = write_lanes(op_kind, byte_mode, table_address[0]);
      end
      if (byte_mode) begin
         mem_wdata = {write_data[7:0], write_data[7:0], write_data[7:0]};
      end else begin
         mem_wdata = {write_data[7:0], write_data};
      end
      s1_valid_d = op_valid;
      s1_kind_d  = op_kind;
      s1_byte_d  = byte_mode;
      s1_sel_d   = table_address[0];
      s1_cfg_d   = cfg_space;
      s1_hit_d   = in_range;
      s1_page_d  = table_page_select;
      s1_addr_d  = table_address;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_valid_q <= 1'b0;
         s1_kind_q  <= table_read_low_word;
         s1_byte_q  <= 1'b0;
         s1_sel_q   <= 1'b0;
         s1_cfg_q   <= 1'b0;
         s1_hit_q   <= 1'b0;
         s1_page_q  <= 8'h00;
         s1_addr_q  <= 16'h0000;
      end else begin
         s1_valid_q <= s1_valid_d;
         s1_kind_q  <= s1_kind_d;
         s1_byte_q  <= s1_byte_d;
         s1_sel_q   <= s1_sel_d;
         s1_cfg_q   <= s1_cfg_d;
         s1_hit_q   <= s1_hit_d;
         s1_page_q  <= s1_page_d;
         s1_addr_q  <= s1_addr_d;
      end
   end

   program_word_store #(
      .ADDR_W (WORD_ADDR_W),
      .LANES  (3)
   ) u_store (
      .ref_clk (ref_clk),
      .lane_we (mem_we),
      .addr    (word_index[WORD_ADDR_W-1:0]),
      .wdata   (mem_wdata),
      .rdata_q (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read formatting and answer registers
   logic [23:0] src_word;
   logic [15:0] fmt_data;
   logic        rd_valid_d;
   logic [15:0] rd_data_d;
   logic        wr_done_d;
   logic        cfg_write_ignored_d;

   always_comb begin
      if (s1_cfg_q) begin
         src_word = cfg_word(s1_page_q, s1_addr_q);
      end else if (s1_hit_q) begin
         src_word = mem_rdata;
      end else begin
         src_word = 24'h000000;
      end
      case (s1_kind_q)
         table_read_low_word: begin
            if (s1_byte_q) begin
               fmt_data = {8'h00, s1_sel_q ? src_word[15:8] : src_word[7:0]};
            end else begin
               fmt_data = src_word[15:0];
            end
         end
         table_read_high_word: begin
            if (s1_byte_q && s1_sel_q) begin
               fmt_data = 16'h0000;
            end else begin
               fmt_data = {8'h00, src_word[23:16]};
            end
         end
         default: fmt_data = 16'h0000;
      endcase
      rd_valid_d = s1_valid_q && is_read_op(s1_kind_q);
      rd_data_d  = rd_valid_d ? fmt_data : rd_data_q;
      wr_done_d  = op_valid && !is_read_op(op_kind);
      cfg_write_ignored_d = op_valid && !is_read_op(op_kind) && cfg_space;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_q          <= 1'b0;
         rd_data_q           <= 16'h0000;
         wr_done_q           <= 1'b0;
         cfg_write_ignored_q <= 1'b0;
      end else begin
         rd_valid_q          <= rd_valid_d;
         rd_data_q           <= rd_data_d;
         wr_done_q           <= wr_done_d;
         cfg_write_ignored_q <= cfg_write_ignored_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter
   logic [23:0] pc_d;

   always_comb begin
      if (pc_load) begin
         pc_d = pc_load_value;
      end else if (pc_step) begin
         pc_d = program_counter_q + `PST_PC_STEP;
      end else begin
         pc_d = program_counter_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         program_counter_q <= 24'h000000;
      end else begin
         program_counter_q <= pc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_PC_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pc_step && !pc_load) |=> program_counter_q == $past(program_counter_q) + 24'h000002)
      else $error("program counter did not step by two");

   AST_READ_ANSWER: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (op_valid && is_read_op(op_kind)) |-> ##2 rd_valid_q)
      else $error("read answer not two cycles after request");

   AST_WRITE_ANSWER: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (op_valid && !is_read_op(op_kind)) |=> wr_done_q)
      else $error("write answer not one cycle after request");

   AST_LOW_WORD_MAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s1_valid_q && s1_kind_q == table_read_low_word && !s1_byte_q && !s1_cfg_q && s1_hit_q)
         |=> rd_data_q == $past(mem_rdata[15:0]))
      else $error("low word read lost program bits");

   AST_LOW_BYTE_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s1_valid_q && s1_kind_q == table_read_low_word && s1_byte_q && s1_sel_q
         && !s1_cfg_q && s1_hit_q)
         |=> rd_data_q == {8'h00, $past(mem_rdata[15:8])})
      else $error("low byte read picked wrong byte");

   AST_HIGH_WORD_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (op_valid && op_kind == table_read_high_word && !byte_mode)
         |-> ##2 (rd_valid_q && rd_data_q[15:8] == 8'h00))
      else $error("phantom byte not zero");

   AST_HIGH_PHANTOM: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (op_valid && op_kind == table_read_high_word && byte_mode && table_address[0])
         |-> ##2 (rd_valid_q && rd_data_q == 16'h0000))
      else $error("phantom byte read not zero");

   AST_CFG_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (op_valid && !is_read_op(op_kind) && table_page_select[7])
         |-> (mem_we == 3'h0) ##1 (wr_done_q && cfg_write_ignored_q))
      else $error("write reached configuration space");

   AST_CFG_UNIMPL_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (op_valid && is_read_op(op_kind) && table_page_select[7]
         && table_page_select != 8'hFF) |-> ##2 rd_data_q == 16'h0000)
      else $error("unimplemented config read not zero");

   AST_HIGH_LANE_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mem_we[2]) |-> (op_kind == table_write_high_word))
      else $error("upper byte written by a low-word op");
endmodule

//--- verilog/table_access_regs.svh
// Constants for the program-space table access block
`ifndef TABLE_ACCESS_REGS_SVH
`define TABLE_ACCESS_REGS_SVH
`define PST_PC_STEP        24'h000002
`define PST_CFG_SPACE_BIT  7
`define PST_CFG_ID_PAGE    8'hFF
`define PST_CFG_ID_ADDR    16'h0000
`define PST_CFG_REV_ADDR   16'h0002
`define PST_READ_LATENCY   2
`define PST_WRITE_LATENCY  1
`endif

//--- verilog/table_access_pkg.sv
// Types for the program-space table access block
package table_access_pkg;
   typedef enum logic [1:0] {
      table_read_low_word,
      table_read_high_word,
      table_write_low_word,
      table_write_high_word
   } table_op_t;
endpackage

//--- verilog/program_word_store.sv
// 24-bit program word store with byte-lane writes and registered read
`timescale 1ns/1ns
module program_word_store #(
   parameter int ADDR_W = 10,
   parameter int LANES  = 3
) (
   input  wire logic                 ref_clk,
   input  wire logic [LANES-1:0]     lane_we,
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [LANES*8-1:0]   wdata,
   output logic      [LANES*8-1:0]   rdata_q
);
   localparam int DEPTH = 1 << ADDR_W;

   ////////////////////////////////////////////////////////////////////////////
   // One array per byte lane
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [7:0] lane_mem [DEPTH];
         logic [7:0] lane_rd_q;
         always_ff @(posedge ref_clk) begin
            if (lane_we[g]) begin
               lane_mem[addr] <= wdata[g*8 +: 8];
            end
            lane_rd_q <= lane_mem[addr];
         end
         assign rdata_q[g*8 +: 8] = lane_rd_q;
      end
   endgenerate
endmodule

//--- testbench/core_table_model.sv
// Core-side model issuing table requests
`timescale 1ns/1ns
module core_table_model (
   input  wire logic                   ref_clk,
   output logic                        op_valid,
   output table_access_pkg::table_op_t op_kind,
   output logic                        byte_mode,
   output logic      [15:0]            table_address,
   output logic      [7:0]             table_page_select,
   output logic      [15:0]            write_data
);
   import table_access_pkg::*;
   initial begin
      op_valid = 1'b0;
      op_kind = table_read_low_word;
      byte_mode = 1'b0;
      table_address = 16'h0000;
      table_page_select = 8'h00;
      write_data = 16'h0000;
   end
   // One request per edge, page with every op
   task automatic issue(input table_op_t k, input logic bm, input logic [15:0] a,
                        input logic [7:0] p, input logic [15:0] d);
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_kind <= k;
      byte_mode <= bm;
      table_address <= a;
      table_page_select <= p;
      write_data <= d;
   endtask
   // Released address and data lines show inverse of last value
   task automatic idle;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      table_address <= ~table_address;
      write_data <= ~write_data;
   endtask
endmodule

//--- testbench/test_program_space_table_access.sv
// Self-checking bench for the table access block
`timescale 1ns/1ns
module test_program_space_table_access;
   import table_access_pkg::*;
   localparam logic [23:0] ID_W  = 24'h0012AB; // Arbitrary value
   localparam logic [23:0] REV_W = 24'h000301; // Arbitrary value
   logic        ref_clk, rst_n, op_valid, byte_mode, pc_step, pc_load;
   table_op_t   op_kind;
   logic [15:0] table_address, write_data, rd_data_q, a;
   logic [7:0]  table_page_select;
   logic [23:0] pc_load_value, program_counter_q, pc_exp;
   logic        rd_valid_q, wr_done_q, cfg_write_ignored_q;
   logic [23:0] mem [int];
   logic [15:0] rq [$];
   logic        wq [$];
   int          errors, n_checks, seed;
   ////////////////////////////////////////
   program_space_table_access #(.WORD_ADDR_W(4), .DEVICE_ID_WORD(ID_W),
      .DEVICE_REV_WORD(REV_W)) i_program_space_table_access (
      .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_kind(op_kind),
      .byte_mode(byte_mode), .table_address(table_address),
      .table_page_select(table_page_select), .write_data(write_data),
      .pc_step(pc_step), .pc_load(pc_load), .pc_load_value(pc_load_value),
      .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .wr_done_q(wr_done_q),
      .cfg_write_ignored_q(cfg_write_ignored_q),
      .program_counter_q(program_counter_q));
   core_table_model i_core_table_model (
      .ref_clk(ref_clk), .op_valid(op_valid), .op_kind(op_kind),
      .byte_mode(byte_mode), .table_address(table_address),
      .table_page_select(table_page_select), .write_data(write_data));
   ////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Notes expected answer, updates word model, issues op
   task automatic op(input table_op_t k, input logic bm, input logic [15:0] ad,
                     input logic [7:0] p, input logic [15:0] d);
      int          idx;
      logic [23:0] w;
      idx = {p[6:0], ad[15:1]};
      w = 24'h000000;
      if (p == 8'hFF && ad[15:1] == 15'h0000) w = ID_W;
      if (p == 8'hFF && ad[15:1] == 15'h0001) w = REV_W;
      if (!p[7] && mem.exists(idx)) w = mem[idx];
      case (k)
         table_read_low_word: rq.push_back(!bm ? w[15:0] : {8'h00, ad[0] ? w[15:8] : w[7:0]});
         table_read_high_word: rq.push_back((bm && ad[0]) ? 16'h0000 : {8'h00, w[23:16]});
         default: begin
            wq.push_back(p[7]);
            if (!p[7] && idx < 16) begin
               if (k == table_write_low_word && !bm) w[15:0] = d;
               else if (k == table_write_low_word && ad[0]) w[15:8] = d[7:0];
               else if (k == table_write_low_word) w[7:0] = d[7:0];
               else if (!(bm && ad[0])) w[23:16] = d[7:0];
               mem[idx] = w;
            end
         end
      endcase
      i_core_table_model.issue(k, bm, ad, p, d);
   endtask
   ////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      #1;
      if (rd_valid_q === 1'b1 && rq.size() == 0) check(24'h1, 24'h0);
      else if (rd_valid_q === 1'b1)
         check(rd_data_q, rq.pop_front());
      if (wr_done_q === 1'b1 && wq.size() == 0) check(24'h1, 24'h0);
      else if (wr_done_q === 1'b1) check(cfg_write_ignored_q, wq.pop_front());
   end
   initial begin
      #1000000;
      errors++;
      finish_test();
   end
   initial begin
      seed = 32'hD40B;
      errors = 0;
      n_checks = 0;
      rst_n = 1'b0;
      pc_step = 1'b0;
      pc_load = 1'b0;
      pc_load_value = 24'h000000;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      // Whole words first, then random mixed ops back to back
      for (int i = 0; i < 8; i++) begin
         op(table_write_low_word, 1'b0, 16'(i * 2), 8'h00, 16'($random(seed)));
         op(table_write_high_word, 1'b0, 16'(i * 2), 8'h00, 16'($random(seed)));
      end
      for (int i = 0; i < 80; i++) begin
         a = {12'h000, 3'($random(seed)), 1'($random(seed))};
         op(table_op_t'(2'($random(seed))), 1'($random(seed)), a, 8'h00, 16'($random(seed)));
      end
      // Config writes vanish, ID words readable, rest zero
      op(table_write_low_word, 1'b0, 16'h0000, 8'hFF, 16'hFFFF);
      op(table_write_high_word, 1'b1, 16'h0000, 8'h80, 16'h00FF);
      for (int i = 0; i < 6; i++) op(table_op_t'(2'(i % 2)), 1'b0, 16'(i / 2 * 2), 8'hFF, 16'h0);
      op(table_read_low_word, 1'b0, 16'h0000, 8'hFE, 16'h0000);
      op(table_read_low_word, 1'b0, 16'h0000, 8'h00, 16'h0000);
      op(table_read_high_word, 1'b0, 16'h0000, 8'h80, 16'h0000);
      // Out-of-range user word: write dropped, read zero
      op(table_write_low_word, 1'b0, 16'h0040, 8'h00, 16'h1234);
      op(table_read_low_word, 1'b0, 16'h0040, 8'h00, 16'h0000);
      i_core_table_model.idle();
      for (int i = 0; i < 20 && rq.size() + wq.size() > 0; i++) @(posedge ref_clk);
      if (rq.size() + wq.size() > 0) errors++;
      // Program counter: load wins, then two per word
      pc_exp = 24'($random(seed)) & 24'hFFFFFE;
      pc_load_value <= pc_exp;
      pc_load <= 1'b1;
      pc_step <= 1'b1;
      @(posedge ref_clk);
      pc_load <= 1'b0;
      repeat (5) @(posedge ref_clk);
      pc_step <= 1'b0;
      @(posedge ref_clk);
      #1;
      check(program_counter_q, pc_exp + 24'h00000A);
      finish_test();
   end
endmodule
